// ---- hw/dsau_pkg.sv ----
// Shared constants and carriers for the data space access unit
package dsau_pkg;
  localparam int AW = 16;
  localparam int DW = 16;
  // Address map of the data space (plain defaults for a generic part)
  localparam logic [15:0] Y_BASE = 16'h1800;
  localparam logic [15:0] Y_LAST = 16'h1FFF;
  localparam logic [15:0] MEM_LAST = 16'h27FF;
  localparam logic [15:0] SFR_TOP = 16'h0800;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam int NEAR_W = 13;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Register port offsets
  localparam logic [3:0] REG_STACK_LIMIT = 4'h0;
  localparam logic [3:0] REG_STACK_PTR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_MOD_START = 4'h3;
  localparam logic [3:0] REG_MOD_END = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  localparam int CTRL_XMOD = 0;
  localparam int CTRL_YMOD = 1;
  localparam int CTRL_BREV = 2;

  // Kind of access requested by the core
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_PUSH = 3'h2, OP_POP = 3'h3,
    OP_MAC = 3'h4, OP_CALL = 3'h5, OP_EXC = 3'h6, OP_IDLE = 3'h7
  } op_t;

  typedef enum logic [1:0] {
    AM_INDIRECT = 2'h0, AM_POSTINC = 2'h1, AM_NEAR = 2'h2, AM_DIRECT16 = 2'h3
  } amode_t;

  typedef struct packed {
    op_t op;
    amode_t amode;
    logic byte_op;
    logic [15:0] ptr;
    logic [15:0] wdata;
    logic [15:0] pc_hi;
    logic [7:0] status_low_byte;
  } req_t;

  typedef struct packed {
    logic [15:0] x_ptr;
    logic [15:0] y_ptr;
  } mac_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [2:0] op;
    logic byte_op;
  } fault_t;
endpackage

// ---- hw/data_space_access_unit.sv ----
// Data space access unit: X/Y paths, alignment, stack pointer and limit checks
// What this block does
// R1 - Every data write goes over the X write bus; Y bus only reads.
// R2 - MAC prefetch: Y pointers address Y space, X pointers X space, concurrently.
// R3 - Accumulator write-back uses X bus and may target any data address.
// R4 - Bit-reversed addressing applies only to X space writes.
// R5 - Modulo addressing available on X accesses and Y prefetches.
// R6 - MAC prefetch crossing into the other space returns zero.
// R7 - Unimplemented address returns zero and raises address error trap.
// R8 - Addresses are 16-bit byte addresses over 64 Kbytes of words.
// R9 - Byte read fetches word, bit 0 picks byte, placed on low lane.
// R10 - Byte write strobes only the matching lane; shared word decode.
// R11 - Y read path fetches words only.
// R12 - Post-increment steps one for bytes, two for words.
// R13 - Odd word access traps; read completes, write is suppressed.
// R14 - Byte load updates only the low byte of the register.
// R15 - Near direct reaches 0x0000-0x1FFF by 13 bits; move direct uses 16 bits.
// R16 - Stack pointer names first free word, post-increments push, pre-decrements pop.
// R17 - Call push zero-extends upper PC word.
// R18 - Exception push places status low byte in upper PC word high byte.
// R19 - Stack limit not reset; its bit 0 reads zero.
// R20 - Stack address compared with limit; push at equal ok, next push traps.
// R21 - Stack address below 0x0800 raises stack error trap.
// R22 - Software avoids stack-pointer indirect read right after a limit write.
// R23 - Address and stack error traps are separate pulses with fault context.
`timescale 1ns/1ns
`default_nettype none
module data_space_access_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core access request
  input wire logic req_valid,
  input wire dsau_pkg::req_t req,
  input wire logic [15:0] dest_reg_old,
  input wire logic mac_valid,
  input wire dsau_pkg::mac_req_t mac_req,
  // Memory array (word decode, lane strobes)
  output logic [14:0] mem_word_addr_ff,
  output logic [1:0] mem_lane_we_ff,
  output logic [15:0] mem_wdata_ff,
  output logic [14:0] mem_y_word_addr_ff,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] mem_y_rdata,
  // Results to the core
  output logic [15:0] x_rdata_ff,
  output logic [15:0] y_rdata_ff,
  output logic [15:0] dest_reg_new_ff,
  output logic [15:0] ptr_next_ff,
  output logic [15:0] stack_ptr_ff,
  // Traps with fault context
  output logic addr_err_ff,
  output logic stack_err_ff,
  output dsau_pkg::fault_t fault_ff,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff
);
  import dsau_pkg::*;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= Y_BASE) && (a <= Y_LAST);
  endfunction

  function automatic logic unimpl(input logic [15:0] a);
    // Upper half is program-space window, treated as unmapped here
    unimpl = (a > MEM_LAST);
  endfunction

  // Wraps to the window start once the address passes the window end
  function automatic logic [15:0] modwrap(input logic [15:0] a, input logic [15:0] s,
                                          input logic [15:0] e, input logic en);
    modwrap = (en && (a > e)) ? s : a;
  endfunction

  // Mirrors bits 15..1 and keeps bit 0 clear, so a reversed word pointer
  // stays word aligned
  function automatic logic [15:0] bitrev(input logic [15:0] a);
    logic [15:0] r;
    r = ZERO_WORD;
    for (int i = 1; i < 16; i++) begin
      r[i] = a[16-i];
    end
    bitrev = r;
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [15:0] stack_limit_ff;
  logic [15:0] mod_start_ff;
  logic [15:0] mod_end_ff;
  logic [2:0] ctrl_ff;
  // Status bit 0 records address errors, bit 1 stack errors
  logic [1:0] status_ff;
  logic [15:0] nxt_sp;
  logic [15:0] ea;
  logic [15:0] step;
  logic is_stack, is_write, misaligned, bad_addr, stack_bad;
  logic [15:0] push_word;

  // Stack limit has no reset; bit 0 is held at zero
  // A new limit is compared at once; software keeps stack reads clear of it
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr == REG_STACK_LIMIT) begin
      stack_limit_ff <= {reg_wdata[15:1], 1'b0}; // R19
    end
  end

  // Modulo window and mode control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_start_ff <= ZERO_WORD;
      mod_end_ff <= ZERO_WORD;
      ctrl_ff <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == REG_MOD_START) begin
        mod_start_ff <= {reg_wdata[15:1], 1'b0};
      end
      if (reg_wr && reg_addr == REG_MOD_END) begin
        mod_end_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_ff <= reg_wdata[2:0];
      end
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= ZERO_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STACK_LIMIT: reg_rdata_ff <= {stack_limit_ff[15:1], 1'b0}; // R19
        REG_STACK_PTR: reg_rdata_ff <= stack_ptr_ff;
        REG_STATUS: reg_rdata_ff <= {14'h0000, status_ff};
        REG_MOD_START: reg_rdata_ff <= mod_start_ff;
        REG_MOD_END: reg_rdata_ff <= mod_end_ff;
        REG_CTRL: reg_rdata_ff <= {13'h0000, ctrl_ff};
        default: reg_rdata_ff <= ZERO_WORD;
      endcase
    end else begin
      reg_rdata_ff <= ZERO_WORD;
    end
  end

  // ==========================================================================
  // Effective address generation
  // ==========================================================================
  always_comb begin
    is_stack = (req.op == OP_PUSH) || (req.op == OP_POP) || (req.op == OP_CALL) ||
               (req.op == OP_EXC);
    is_write = (req.op == OP_WRITE) || (req.op == OP_PUSH) || (req.op == OP_CALL) ||
               (req.op == OP_EXC); // R1 R3
    step = req.byte_op ? STEP_BYTE : STEP_WORD; // R12
    nxt_sp = stack_ptr_ff;
    ea = req.ptr;
    case (req.amode)
      AM_NEAR: ea = {3'b000, req.ptr[NEAR_W-1:0]}; // R15
      AM_DIRECT16: ea = req.ptr; // R15
      default: ea = req.ptr; // R8
    endcase
    // Bit reversal only for X writes
    if (ctrl_ff[CTRL_BREV] && req.op == OP_WRITE && req.amode == AM_POSTINC) begin
      ea = bitrev(req.ptr); // R4
    end
    // Stack operations override the pointer field: pushes use the free word,
    // pops the word just below it
    if (req.op == OP_PUSH || req.op == OP_CALL || req.op == OP_EXC) begin
      ea = stack_ptr_ff; // R16
      nxt_sp = stack_ptr_ff + STEP_WORD;
    end else if (req.op == OP_POP) begin
      ea = stack_ptr_ff - STEP_WORD; // R16
      nxt_sp = ea;
    end
    misaligned = !req.byte_op && ea[0]; // R13
    bad_addr = unimpl(ea); // R7
    // Equal to limit passes, beyond it traps; below SFR top always traps
    stack_bad = is_stack && ((ea > stack_limit_ff) || (ea < SFR_TOP)); // R20 R21
    // Upper PC word: zero high byte on call, status byte on exception
    push_word = req.wdata;
    if (req.op == OP_CALL) begin
      push_word = {ZERO_BYTE, req.pc_hi[7:0]}; // R17
    end else if (req.op == OP_EXC) begin
      push_word = {req.status_low_byte, req.pc_hi[7:0]}; // R18
    end
  end

  // ==========================================================================
  // X path: memory strobes, read data, pointer update
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_word_addr_ff <= 15'h0000;
      mem_lane_we_ff <= 2'b00;
      mem_wdata_ff <= ZERO_WORD;
      ptr_next_ff <= ZERO_WORD;
    end else begin
      mem_lane_we_ff <= 2'b00;
      if (req_valid && req.op != OP_IDLE) begin
        mem_word_addr_ff <= ea[15:1]; // R10
        // Misaligned or unmapped writes are dropped; stack overflow still writes
        if (is_write && !misaligned && !bad_addr) begin // R13 R1
          if (req.byte_op) begin
            mem_lane_we_ff <= ea[0] ? 2'b10 : 2'b01; // R10
            mem_wdata_ff <= {push_word[7:0], push_word[7:0]};
          end else begin
            mem_lane_we_ff <= 2'b11;
            mem_wdata_ff <= push_word;
          end
        end
        ptr_next_ff <= modwrap(req.ptr + step, mod_start_ff, mod_end_ff,
                               ctrl_ff[CTRL_XMOD]); // R12 R5
      end else if (mac_valid) begin
        // A core access owns the X bus; a prefetch drives it only when idle
        mem_word_addr_ff <= mac_req.x_ptr[15:1]; // R2
      end
    end
  end

  // Read return captured one cycle after the address
  logic rd_pending_ff, rd_byte_ff, rd_hi_ff, rd_zero_ff;
  logic [15:0] rd_old_ff;
  logic x_cross_ff, y_cross_ff, mac_pend_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_pending_ff <= 1'b0;
      rd_byte_ff <= 1'b0;
      rd_hi_ff <= 1'b0;
      rd_zero_ff <= 1'b0;
      rd_old_ff <= ZERO_WORD;
    end else begin
      rd_pending_ff <= req_valid && (req.op == OP_READ || req.op == OP_POP);
      rd_byte_ff <= req.byte_op;
      rd_hi_ff <= ea[0];
      rd_zero_ff <= bad_addr; // R7
      rd_old_ff <= dest_reg_old;
    end
  end

  // Byte reads select the lane and merge into the destination low byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      x_rdata_ff <= ZERO_WORD;
      dest_reg_new_ff <= ZERO_WORD;
    end else if (rd_pending_ff) begin
      if (rd_zero_ff) begin
        x_rdata_ff <= ZERO_WORD; // R7
        dest_reg_new_ff <= rd_byte_ff ? {rd_old_ff[15:8], ZERO_BYTE} : ZERO_WORD;
      end else if (rd_byte_ff) begin
        x_rdata_ff <= {ZERO_BYTE, rd_hi_ff ? mem_rdata[15:8] : mem_rdata[7:0]}; // R9
        dest_reg_new_ff <= {rd_old_ff[15:8],
                            rd_hi_ff ? mem_rdata[15:8] : mem_rdata[7:0]}; // R14
      end else begin
        x_rdata_ff <= mem_rdata;
        dest_reg_new_ff <= mem_rdata;
      end
    end else if (mac_pend_ff) begin
      // Prefetch operand shares the X read path; the destination register is
      // left alone, only the operand moves
      x_rdata_ff <= x_cross_ff ? ZERO_WORD : mem_rdata; // R2 R6
    end
  end

  // ==========================================================================
  // MAC dual prefetch: X pointer on X bus, Y pointer on read-only Y bus
  // ==========================================================================
  logic [15:0] y_ea;
  // Y modulo wraps the pointer before the space check, so a prefetch that
  // wraps back into Y is not a crossing
  always_comb begin
    y_ea = modwrap(mac_req.y_ptr, mod_start_ff, mod_end_ff, ctrl_ff[CTRL_YMOD]); // R5
  end

  // Y bus carries word addresses only, never a write strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_y_word_addr_ff <= 15'h0000;
      x_cross_ff <= 1'b0;
      y_cross_ff <= 1'b0;
      mac_pend_ff <= 1'b0;
    end else begin
      mac_pend_ff <= mac_valid;
      if (mac_valid) begin
        mem_y_word_addr_ff <= y_ea[15:1]; // R2 R11
        x_cross_ff <= in_y(mac_req.x_ptr); // R6
        y_cross_ff <= !in_y(y_ea); // R6
      end
    end
  end

  // Crossed prefetches return zero words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      y_rdata_ff <= ZERO_WORD;
    end else if (mac_pend_ff) begin
      y_rdata_ff <= y_cross_ff ? ZERO_WORD : mem_y_rdata; // R6 R11
    end
  end

  // ==========================================================================
  // Stack pointer and traps
  // ==========================================================================
  // A software write of the pointer wins over a stack access in the same
  // cycle; bit 0 is forced low so the stack stays word aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_ptr_ff <= SP_RESET;
    end else if (reg_wr && reg_addr == REG_STACK_PTR) begin
      stack_ptr_ff <= {reg_wdata[15:1], 1'b0};
    end else if (req_valid && is_stack) begin
      stack_ptr_ff <= nxt_sp; // R16
    end
  end

  // One-cycle trap pulses with the faulting context; status keeps them sticky
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_err_ff <= 1'b0;
      stack_err_ff <= 1'b0;
      fault_ff <= '0;
      status_ff <= 2'b00;
    end else begin
      addr_err_ff <= req_valid && (misaligned || bad_addr); // R7 R13 R23
      stack_err_ff <= req_valid && stack_bad; // R20 R21 R23
      if (req_valid && (misaligned || bad_addr || stack_bad)) begin
        fault_ff <= '{addr: ea, op: req.op, byte_op: req.byte_op}; // R23
      end
      // Set wins over a software clear in the same cycle
      status_ff[0] <= (req_valid && (misaligned || bad_addr)) ||
                      (status_ff[0] && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[0]));
      status_ff[1] <= (req_valid && stack_bad) ||
                      (status_ff[1] && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[1]));
    end
  end
endmodule
`default_nettype wire

// ---- bench/dsau_properties.sv ----
// Port checker for the data space access unit
`timescale 1ns/1ns
`default_nettype none
module dsau_properties
  import dsau_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests
  input wire logic req_valid,
  input wire dsau_pkg::req_t req,
  input wire logic mac_valid,
  input wire dsau_pkg::mac_req_t mac_req,
  // Results
  input wire logic [1:0] mem_lane_we_ff,
  input wire logic [15:0] x_rdata_ff,
  input wire logic [15:0] y_rdata_ff,
  input wire logic [15:0] ptr_next_ff,
  input wire logic [15:0] stack_ptr_ff,
  input wire logic addr_err_ff,
  input wire logic stack_err_ff
);
  // ==========
  // Helpers
  logic ind_wr;
  // Only implemented addresses may strobe a lane
  assign ind_wr = req_valid && req.op == OP_WRITE && req.amode == AM_INDIRECT &&
                  req.ptr <= MEM_LAST;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A trap then a zero answer one cycle later
  sequence s_zero_read;
    addr_err_ff ##1 (x_rdata_ff == ZERO_WORD);
  endsequence
  chk_byte_lane: assert property (
    ind_wr && req.byte_op |=> mem_lane_we_ff == {$past(req.ptr[0]), !$past(req.ptr[0])})
    else $error("byte write on wrong lane");
  chk_odd_word: assert property (
    req_valid && req.op == OP_WRITE && !req.byte_op && req.amode == AM_INDIRECT && req.ptr[0]
    |=> addr_err_ff && mem_lane_we_ff == 2'h0)
    else $error("odd word write not refused");
  chk_unimpl_read: assert property (
    req_valid && req.op == OP_READ && req.amode == AM_INDIRECT && req.ptr > MEM_LAST
    |=> s_zero_read)
    else $error("unimplemented read not zero");
  chk_post_step: assert property (
    req_valid && req.op == OP_READ && req.amode == AM_POSTINC
    |=> ptr_next_ff == $past(req.ptr) + ($past(req.byte_op) ? STEP_BYTE : STEP_WORD))
    else $error("wrong post step");
  chk_push_step: assert property (
    req_valid && req.op == OP_PUSH |=> stack_ptr_ff == $past(stack_ptr_ff) + STEP_WORD)
    else $error("push did not advance");
  chk_sp_floor: assert property (
    req_valid && req.op == OP_PUSH && stack_ptr_ff < SFR_TOP |=> stack_err_ff)
    else $error("underflow not trapped");
  chk_y_cross: assert property (
    mac_valid && (mac_req.y_ptr < Y_BASE || mac_req.y_ptr > Y_LAST)
    |=> ##1 y_rdata_ff == ZERO_WORD)
    else $error("cross prefetch not zero");
  chk_trap_cause: assert property (
    stack_err_ff |-> $past(req_valid) && $past(req.op) inside {OP_PUSH, OP_POP, OP_CALL, OP_EXC})
    else $error("stack trap without stack op");
endmodule
bind data_space_access_unit dsau_properties chk_i (.clk_sys, .rst, .req_valid, .req, .mac_valid,
  .mac_req, .mem_lane_we_ff, .x_rdata_ff, .y_rdata_ff, .ptr_next_ff, .stack_ptr_ff, .addr_err_ff,
  .stack_err_ff);
`default_nettype wire

// ---- bench/dsau_mem_model.sv ----
// Behavioural data memory behind the access unit
`timescale 1ns/1ns
`default_nettype none
module dsau_mem_model (
  // Clock
  input wire logic clk_sys,
  // X bus
  input wire logic [14:0] word_addr,
  input wire logic [1:0] lane_we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  // Y bus, reads only
  input wire logic [14:0] y_word_addr,
  output logic [15:0] y_rdata
);
  logic [15:0] mem [0:32767];
  // Reads follow the registered addresses with no delay
  assign rdata = mem[word_addr];
  assign y_rdata = mem[y_word_addr];
  // Shared word decode, one write line per lane
  always_ff @(posedge clk_sys) begin
    if (lane_we[0]) mem[word_addr][7:0] <= wdata[7:0];
    if (lane_we[1]) mem[word_addr][15:8] <= wdata[15:8];
  end
endmodule
`default_nettype wire

// ---- bench/data_space_access_unit_bench.sv ----
// Self-checking bench for the data space access unit
`timescale 1ns/1ns
`default_nettype none
module data_space_access_unit_bench;
  import dsau_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic req_valid = 0;
  req_t req = '0;
  mac_req_t mac_req = '0;
  logic mac_valid = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [14:0] wa, ya;
  logic [1:0] we;
  logic [15:0] wd, md, myd, xr, yr, dn, pn, sp, rr;
  logic ae, se;
  fault_t ft;
  int n_fail = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  data_space_access_unit dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
    .dest_reg_old(16'hBEEF), .mac_valid(mac_valid), .mac_req(mac_req), .mem_word_addr_ff(wa),
    .mem_lane_we_ff(we), .mem_wdata_ff(wd), .mem_y_word_addr_ff(ya), .mem_rdata(md),
    .mem_y_rdata(myd), .x_rdata_ff(xr), .y_rdata_ff(yr), .dest_reg_new_ff(dn), .ptr_next_ff(pn),
    .stack_ptr_ff(sp), .addr_err_ff(ae), .stack_err_ff(se), .fault_ff(ft), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rr));
  dsau_mem_model mem_i (.clk_sys(clk_sys), .word_addr(wa), .lane_we(we), .wdata(wd), .rdata(md),
    .y_word_addr(ya), .y_rdata(myd));
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic nx;
    @(posedge clk_sys);
    #1;
  endtask
  // One request cycle; returns once the first answer has settled
  task automatic acc(input op_t op, input amode_t am, input logic b, input logic [15:0] p,
      input logic [15:0] w);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op, am, b, p, w, 16'h77A5, 8'h3C};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req.op <= OP_IDLE;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(rr, exp);
  endtask
  task automatic mac(input logic [15:0] x, input logic [15:0] y, input logic [15:0] xe,
      input logic [15:0] ye);
    @(posedge clk_sys);
    mac_valid <= 1'b1;
    mac_req <= '{x, y};
    @(posedge clk_sys);
    mac_valid <= 1'b0;
    nx();
    chk(xr, xe);
    chk(yr, ye);
  endtask
  // The upper pushed word lands at the free word the pointer named
  task automatic up(input logic [14:0] a, input logic [15:0] e);
    chk(mem_i.mem[a], e);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the hundred-odd cycles the tests take
  initial begin
    #50000;
    n_fail++;
    conclude();
  end
  // ==========
  // Tests
  initial begin
    req.op = OP_IDLE;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    chk(sp, SP_RESET);
    wr(REG_STACK_LIMIT, 16'h0805);
    rdr(REG_STACK_LIMIT, 16'h0804);
    rdr(4'hF, 16'h0000);
    rdr(REG_STACK_PTR, SP_RESET);
    $display("registers done");
    acc(OP_WRITE, AM_INDIRECT, 1'b0, 16'h1000, 16'hA1B2);
    chk({14'h0, we}, 16'h0003);
    chk({1'b0, wa}, 16'h0800);
    acc(OP_WRITE, AM_INDIRECT, 1'b1, 16'h1001, 16'h00C3);
    chk({14'h0, we}, 16'h0002);
    acc(OP_READ, AM_POSTINC, 1'b1, 16'h1001, 16'h0000);
    chk(pn, 16'h1002);
    nx();
    chk({8'h00, xr[7:0]}, 16'h00C3);
    chk(dn, 16'hBEC3);
    acc(OP_READ, AM_POSTINC, 1'b0, 16'h1000, 16'h0000);
    chk(pn, 16'h1002);
    nx();
    chk(xr, 16'hC3B2);
    acc(OP_WRITE, AM_INDIRECT, 1'b0, 16'h1003, 16'hFFFF);
    chk({15'h0, ae}, 16'h0001);
    chk({14'h0, we}, 16'h0000);
    chk(ft.addr, 16'h1003);
    acc(OP_READ, AM_INDIRECT, 1'b0, 16'h3000, 16'h0000);
    chk({15'h0, ae}, 16'h0001);
    nx();
    chk(xr, 16'h0000);
    acc(OP_READ, AM_NEAR, 1'b0, 16'h1FFE, 16'h0000);
    chk({1'b0, wa}, 16'h0FFF);
    acc(OP_READ, AM_DIRECT16, 1'b0, 16'h2000, 16'h0000);
    chk({1'b0, wa}, 16'h1000);
    acc(OP_WRITE, AM_INDIRECT, 1'b0, 16'h1800, 16'h5A5A);
    mac(16'h1000, 16'h1800, 16'hC3B2, 16'h5A5A);
    mac(16'h1800, 16'h1000, 16'h0000, 16'h0000);
    wr(REG_MOD_START, 16'h1000);
    wr(REG_MOD_END, 16'h1003);
    wr(REG_CTRL, 16'h0001);
    acc(OP_WRITE, AM_POSTINC, 1'b0, 16'h1002, 16'h0000);
    chk(pn, 16'h1000);
    wr(REG_CTRL, 16'h0004);
    acc(OP_WRITE, AM_POSTINC, 1'b0, 16'h0010, 16'h6B6B);
    chk({1'b0, wa}, 16'h0800);
    acc(OP_READ, AM_POSTINC, 1'b0, 16'h0010, 16'h0000);
    chk({1'b0, wa}, 16'h0008);
    wr(REG_MOD_START, 16'h1800);
    wr(REG_MOD_END, 16'h1801);
    wr(REG_CTRL, 16'h0002);
    mac(16'h1000, 16'h1804, 16'h6B6B, 16'h5A5A);
    $display("data paths done");
    for (int i = 0; i < 4; i++) begin
      acc(OP_PUSH, AM_INDIRECT, 1'b0, 16'h0000, 16'h1110 + 16'(i));
      chk({15'h0, se}, {15'h0, i == 3});
      chk(sp, 16'h0802 + 16'(2 * i));
    end
    acc(OP_POP, AM_INDIRECT, 1'b0, 16'h0000, 16'h0000);
    chk(sp, 16'h0806);
    nx();
    chk(xr, 16'h1113);
    wr(REG_STACK_PTR, 16'h07FE);
    acc(OP_PUSH, AM_INDIRECT, 1'b0, 16'h0000, 16'h0000);
    chk({15'h0, se}, 16'h0001);
    chk(ft.addr, 16'h07FE);
    rdr(REG_STATUS, 16'h0003);
    wr(REG_STATUS, 16'h0003);
    rdr(REG_STATUS, 16'h0000);
    wr(REG_STACK_LIMIT, 16'h0FFE);
    wr(REG_STACK_PTR, 16'h0900);
    acc(OP_CALL, AM_INDIRECT, 1'b0, 16'h0000, 16'h1234);
    repeat (3) nx();
    up(15'h0480, 16'h00A5);
    wr(REG_STACK_PTR, 16'h0A00);
    acc(OP_EXC, AM_INDIRECT, 1'b0, 16'h0000, 16'h1234);
    repeat (3) nx();
    up(15'h0500, 16'h3CA5);
    $display("stack done");
    conclude();
  end
endmodule
`default_nettype wire
